/* File: verilog/fbc_flash_bus_ctrl.sv */
// Control-pin logic of a word-wide flash: latching, gating, reset, locking, wait.
// Assumes the command decoder, array and burst path sit on core_clk beside it.
`default_nettype none

module fbc_flash_bus_ctrl
	import fbc_pkg::*;
(
	// Clock and reset.
	input  wire logic           core_clk,
	input  wire logic           nrst,
	// Host pins.
	input  wire fbc_pins_s      pins,
	output logic [DATA_W-1:0]   data_out,
	output logic [DATA_W-1:0]   data_oe,
	output logic                data_pending_n_out,
	output logic                data_pending_n_oe,
	// Read path.
	input  wire logic [DATA_W-1:0] read_data,
	input  wire logic           data_valid,
	input  wire logic           cont_burst,
	input  wire logic           cfg_load,
	input  wire logic           cfg_sync,
	output fbc_read_mode_e      read_mode,
	output logic [ADDR_W-1:0]   latched_addr,
	output logic                burst_tick,
	output logic                device_active,
	// Command interface and automation.
	output logic                cmd_valid,
	output fbc_cmd_s            cmd,
	input  wire fbc_op_s        op,
	output logic                op_grant,
	output logic                op_fail,
	output logic                auto_reset,
	input  wire logic           status_clear,
	output fbc_status_s         status
);

	localparam int PIN_W = $bits(fbc_pins_s);

	typedef struct packed {
		logic           latch_prev;
		logic           we_prev;
		logic           burst_prev;
		fbc_read_mode_e mode;
		logic [ADDR_W-1:0] addr_lat;
		logic           cmd_valid;
		fbc_cmd_s       cmd;
		fbc_status_s    status;
		logic           op_grant;
		logic           op_fail;
		logic [DATA_W-1:0] data_out;
		logic           data_oe;
		logic           wait_val;
		logic           wait_oe;
		logic           burst_tick;
	} fbc_core_s;

	fbc_pins_s ps;
	fbc_core_s st;
	fbc_core_s next_st;
	logic      rst_ok;
	logic      read_gate;
	logic      wait_gate;
	logic      latch_rise;
	logic      we_rise;
	logic      locked;

	// Every host pin passes two flip-flops before use.
	fbc_sync #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        (pins),
		.q        (ps)
	);

	// Decoded pin conditions shared by the update logic and the checks.
	assign rst_ok     = ps.hw_reset_n;
	assign read_gate  = !ps.chip_select_n && !ps.output_gate_n && ps.write_strobe_n && rst_ok;
	assign wait_gate  = read_gate && (st.mode == FBC_RM_SYNC) && cont_burst;
	assign latch_rise = ps.addr_latch_n && !st.latch_prev;
	assign we_rise    = ps.write_strobe_n && !st.we_prev;
	assign locked     = !ps.lock_control_n && fbc_lockable(op.addr);

	// Next-state logic for all control state.
	always_comb begin
		next_st            = st;
		next_st.latch_prev = ps.addr_latch_n;
		next_st.we_prev    = ps.write_strobe_n;
		next_st.burst_prev = ps.burst_clk;
		next_st.cmd_valid  = 1'b0;
		next_st.op_grant   = 1'b0;
		next_st.op_fail    = 1'b0;
		next_st.burst_tick = 1'b0;

		// Address follows the pins while the strobe is held low, else latches on its rise.
		if (latch_rise || !ps.addr_latch_n) begin
			next_st.addr_lat = ps.addr;
		end

		// Writes need select, reset released and a healthy core supply.
		if (we_rise && !ps.chip_select_n && rst_ok && !ps.core_supply_low) begin
			next_st.cmd_valid = 1'b1;
			next_st.cmd.addr  = ps.addr;
			next_st.cmd.data  = ps.data;
		end

		// Software clears flags first so a same-cycle lock failure still sets them.
		if (status_clear) begin
			next_st.status = fbc_status_s'(STATUS_RESET);
		end

		// Program or erase admission.
		if (op.start && rst_ok) begin
			if (ps.prog_supply_low) begin
				next_st.op_fail = 1'b1;
			end else if (locked) begin
				next_st.op_fail                = 1'b1;
				next_st.status.lock_error_flag = 1'b1;
				if (op.is_erase) begin
					next_st.status.erase_error_flag = 1'b1;
				end else begin
					next_st.status.program_error_flag = 1'b1;
				end
			end else begin
				next_st.op_grant = 1'b1;
			end
		end

		// Read mode changes only by configuration outside reset.
		if (cfg_load && rst_ok) begin
			next_st.mode = cfg_sync ? FBC_RM_SYNC : FBC_RM_ASYNC;
		end

		// Data pins drive only while selected and gated.
		next_st.data_oe  = read_gate;
		next_st.data_out = read_data;

		// Wait drives data-valid state only in continuous burst with gate and select.
		next_st.wait_oe  = wait_gate;
		next_st.wait_val = wait_gate ? data_valid : 1'b1;

		// Burst clock edges count only during synchronous reads.
		if (ps.burst_clk && !st.burst_prev && (st.mode == FBC_RM_SYNC) && read_gate) begin
			next_st.burst_tick = 1'b1;
		end

		// Reset pin: async read mode, cleared flags, no writes or operations.
		if (!rst_ok) begin
			next_st.mode      = FBC_RM_ASYNC;
			next_st.status    = fbc_status_s'(STATUS_RESET);
			next_st.cmd_valid = 1'b0;
			next_st.op_grant  = 1'b0;
			// Edge memories idle high so reset exit shows no false strobe rise.
			next_st.latch_prev = 1'b1;
			next_st.we_prev    = 1'b1;
		end
	end

	// State register with constant reset values.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st            <= '0;
			st.latch_prev <= 1'b1;
			st.we_prev    <= 1'b1;
			st.mode       <= FBC_RM_ASYNC;
			st.wait_val   <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Output wiring from the state register.
	assign data_out           = st.data_out;
	assign data_oe            = {DATA_W{st.data_oe}};
	assign data_pending_n_out = st.wait_val;
	assign data_pending_n_oe  = st.wait_oe;
	assign read_mode          = st.mode;
	assign latched_addr       = st.addr_lat;
	assign burst_tick         = st.burst_tick;
	assign cmd_valid          = st.cmd_valid;
	assign cmd                = st.cmd;
	assign op_grant           = st.op_grant;
	assign op_fail            = st.op_fail;
	assign status             = st.status;
	// Standby whenever deselected or held in reset.
	assign device_active      = !ps.chip_select_n && rst_ok;
	// Automation is held reset while the reset pin is low.
	assign auto_reset         = !rst_ok;

	// Reset pin forces asynchronous read on the next edge.
	a_reset_async_mode: assert property (@(posedge core_clk) disable iff (!nrst)
		!rst_ok |=> st.mode == FBC_RM_ASYNC)
		else $error("Read mode not async after reset pin");

	// Reset pin clears all status flags.
	a_reset_clears_flags: assert property (@(posedge core_clk) disable iff (!nrst)
		!rst_ok |=> st.status == fbc_status_s'(STATUS_RESET))
		else $error("Status flags not cleared by reset pin");

	// No write reaches the command interface during reset.
	a_reset_blocks_write: assert property (@(posedge core_clk) disable iff (!nrst)
		!rst_ok |=> !st.cmd_valid && !st.op_grant)
		else $error("Write or grant issued during reset");

	// Low core supply suppresses writes.
	a_core_low_write: assert property (@(posedge core_clk) disable iff (!nrst)
		ps.core_supply_low |=> !st.cmd_valid)
		else $error("Write accepted at low core supply");

	// Write strobe rise with select passes the pin address on.
	a_write_capture: assert property (@(posedge core_clk) disable iff (!nrst)
		we_rise && !ps.chip_select_n && rst_ok && !ps.core_supply_low
		|=> st.cmd_valid && st.cmd.addr == $past(ps.addr))
		else $error("Write strobe did not capture address");

	// Address latch rise stores the pin address.
	a_addr_latch: assert property (@(posedge core_clk) disable iff (!nrst)
		latch_rise |=> st.addr_lat == $past(ps.addr))
		else $error("Address not latched on strobe rise");

	// Data pins drive only after a gated, selected cycle.
	a_data_gate: assert property (@(posedge core_clk) disable iff (!nrst)
		st.data_oe |-> $past(!ps.output_gate_n && !ps.chip_select_n))
		else $error("Data driven without gate and select");

	// Wait pin drives only after a gated, selected cycle.
	a_wait_gate: assert property (@(posedge core_clk) disable iff (!nrst)
		st.wait_oe |-> $past(!ps.output_gate_n && !ps.chip_select_n))
		else $error("Wait driven outside its gating");

	// A locked block fails and sets the lock flag.
	a_lock_fail: assert property (@(posedge core_clk) disable iff (!nrst)
		op.start && rst_ok && !ps.prog_supply_low && locked
		|=> st.op_fail && !st.op_grant && st.status.lock_error_flag)
		else $error("Locked block operation not failed");

	// An unlocked block is granted.
	a_unlocked_grant: assert property (@(posedge core_clk) disable iff (!nrst)
		op.start && rst_ok && !ps.prog_supply_low && !locked |=> st.op_grant)
		else $error("Unlocked block operation not granted");

	// Low program supply refuses every change.
	a_supply_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
		op.start && rst_ok && ps.prog_supply_low |=> st.op_fail && !st.op_grant)
		else $error("Operation granted at low program supply");

	// Burst clock is ignored outside synchronous reads.
	a_burst_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
		(st.mode == FBC_RM_ASYNC || !ps.write_strobe_n) |=> !st.burst_tick)
		else $error("Burst clock acted outside sync read");

	// Write strobe rise also passes the pin data on.
	a_write_data: assert property (@(posedge core_clk) disable iff (!nrst)
		we_rise && !ps.chip_select_n && rst_ok && !ps.core_supply_low
		|=> st.cmd.data == $past(ps.data))
		else $error("Write strobe did not capture data");

	// Address holds while the latch strobe stays high.
	a_latch_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		ps.addr_latch_n && !latch_rise |=> $stable(st.addr_lat))
		else $error("Latched address changed without strobe");

	// Deselect or a raised gate floats the data pins.
	a_data_float: assert property (@(posedge core_clk) disable iff (!nrst)
		ps.chip_select_n || ps.output_gate_n |=> !st.data_oe)
		else $error("Data pins driven while deselected or disabled");

	// Wait stays undriven outside continuous synchronous burst.
	a_wait_undriven: assert property (@(posedge core_clk) disable iff (!nrst)
		st.mode != FBC_RM_SYNC || !cont_burst |=> !st.wait_oe)
		else $error("Wait driven outside continuous burst");

	// A driven wait pin shows the read path's data-valid state.
	a_wait_value: assert property (@(posedge core_clk) disable iff (!nrst)
		st.wait_oe |-> st.wait_val == $past(data_valid))
		else $error("Wait value does not follow data valid");

	// Leaving the reset pin finds the read mode asynchronous.
	a_reset_exit: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(rst_ok) |-> st.mode == FBC_RM_ASYNC)
		else $error("Read mode not async at reset exit");

	// A locked failure marks the kind of operation that failed.
	a_lock_kind: assert property (@(posedge core_clk) disable iff (!nrst)
		op.start && rst_ok && !ps.prog_supply_low && locked
		|=> ($past(op.is_erase) ? st.status.erase_error_flag : st.status.program_error_flag))
		else $error("Locked failure flag does not match operation");

	// A refused operation at low program supply leaves the flags alone.
	a_supply_flags: assert property (@(posedge core_clk) disable iff (!nrst)
		op.start && rst_ok && ps.prog_supply_low && !status_clear |=> $stable(st.status))
		else $error("Low program supply changed status flags");

endmodule // fbc_flash_bus_ctrl

`default_nettype wire

/* File: verilog/fbc_pkg.sv */
// Shared constants, types and decode helpers for the flash bus control pins.
// Assumes a top-boot block map and one core clock that samples all pins.
`default_nettype none

package fbc_pkg;

	// Bus widths of the address and data pins.
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;

	// Block field of a word address and the index of a parameter block.
	localparam int BLK_MSB  = 19;
	localparam int BLK_LSB  = 15;
	localparam int PIDX_MSB = 14;
	localparam int PIDX_LSB = 12;

	// Block field value that holds the eight parameter blocks.
	localparam logic [BLK_MSB-BLK_LSB:0] PARAM_REGION = 5'h1F;

	// Parameter blocks that follow the lock pin, one bit per block.
	localparam logic [7:0] LOCKABLE_PARAM_MASK = 8'h03;

	// Reset value of the sticky status flags.
	localparam logic [2:0] STATUS_RESET = 3'h0;

	// Read modes; reset always returns to asynchronous array read.
	typedef enum logic [1:0] {
		FBC_RM_ASYNC = 2'b01,
		FBC_RM_SYNC  = 2'b10
	} fbc_read_mode_e;

	// Host pins, all asynchronous to the core clock.
	typedef struct packed {
		logic              addr_latch_n;
		logic              chip_select_n;
		logic              hw_reset_n;
		logic              output_gate_n;
		logic              write_strobe_n;
		logic              lock_control_n;
		logic              prog_supply_low;
		logic              core_supply_low;
		logic              burst_clk;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbc_pins_s;

	// One write toward the command_interface.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbc_cmd_s;

	// Program or erase request from the command decoder.
	typedef struct packed {
		logic              start;
		logic              is_erase;
		logic [ADDR_W-1:0] addr;
	} fbc_op_s;

	// Sticky status flags.
	typedef struct packed {
		logic erase_error_flag;
		logic program_error_flag;
		logic lock_error_flag;
	} fbc_status_s;

	// True when the block holding this address follows the lock pin.
	function automatic logic fbc_lockable(input logic [ADDR_W-1:0] a);
		logic param;
		param = (a[BLK_MSB:BLK_LSB] == PARAM_REGION);
		return !param || LOCKABLE_PARAM_MASK[a[PIDX_MSB:PIDX_LSB]];
	endfunction

endpackage

`default_nettype wire

/* File: verilog/fbc_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the inputs change slowly against core_clk; groups may skew by a cycle.
`default_nettype none

module fbc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// Raw pins and synchronised copy.
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} fbc_sync_st_s;

	fbc_sync_st_s st;
	fbc_sync_st_s next_st;

	// The first stage feeds only the second stage.
	always_comb begin
		next_st.meta = d;
		next_st.held = st.meta;
	end

	// Both stages clear to zero under reset.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.held;

endmodule // fbc_sync

`default_nettype wire

/* File: tb/fbc_host_model.sv */
// Host-side model: drives the control, address and data pins of the flash.
// Assumes one bench process calls its tasks, one at a time, on core_clk.
`default_nettype none

module fbc_host_model
	import fbc_pkg::*;
(
	// Clock.
	input  wire logic     core_clk,
	// Pins toward the device.
	output var fbc_pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus: strobes and selects inactive, supplies valid.
	initial begin
		pins = '{addr_latch_n: 1'b1, chip_select_n: 1'b1, hw_reset_n: 1'b1, output_gate_n: 1'b1,
			write_strobe_n: 1'b1, lock_control_n: 1'b1, default: '0};
	end

	// Sets {select, gate, reset, lock, program low, core low} and lets them settle.
	task automatic ctl(input logic [5:0] v);
		@(posedge core_clk);
		{pins.chip_select_n, pins.output_gate_n, pins.hw_reset_n, pins.lock_control_n,
			pins.prog_supply_low, pins.core_supply_low} <= v;
		repeat (3) @(posedge core_clk);
	endtask

	// One write pulse; released data shows its inverse so stale values never match.
	task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		pins.addr <= a;
		pins.data <= d;
		pins.write_strobe_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		pins.write_strobe_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		pins.data <= ~d;
		repeat (2) @(posedge core_clk);
	endtask

	// Address phase; with hold the latch stays low as in asynchronous cycles.
	task automatic latch(input logic [ADDR_W-1:0] a, input logic hold);
		@(posedge core_clk);
		pins.addr <= a;
		pins.addr_latch_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		if (!hold) begin
			pins.addr_latch_n <= 1'b1;
			repeat (3) @(posedge core_clk);
			pins.addr <= ~a;
		end
		repeat (3) @(posedge core_clk);
	endtask

	// Burst clock pulses; the clock stands low between bursts.
	task automatic burst(input int n);
		repeat (n) begin
			@(posedge core_clk);
			pins.burst_clk <= 1'b1;
			repeat (3) @(posedge core_clk);
			pins.burst_clk <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask

endmodule // fbc_host_model

`default_nettype wire

/* File: tb/fbc_flash_bus_ctrl_test.sv */
// Self-checking bench for the flash bus control pins.
// Assumes the host model drives the pins and this module the read and op ports.
`default_nettype none

`define CHK(what, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("mismatch %s expected %h seen %h", what, exp, got); \
		end \
	end

module fbc_flash_bus_ctrl_test;
	import fbc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic              core_clk, nrst, data_valid, cont_burst, cfg_load, cfg_sync, status_clear;
	logic              data_pending_n_out, data_pending_n_oe, burst_tick, device_active;
	logic              cmd_valid, op_grant, op_fail, auto_reset;
	logic [DATA_W-1:0] read_data, data_out, data_oe;
	logic [ADDR_W-1:0] latched_addr;
	fbc_pins_s         pins;
	fbc_read_mode_e    read_mode;
	fbc_cmd_s          cmd;
	fbc_op_s           op;
	fbc_status_s       status;
	int                n_fail, n_checks, n_cmd, n_grant, n_ref, n_tick, cycles;

	fbc_host_model u_fbc_host_model (
		.core_clk (core_clk),
		.pins     (pins)
	);
	fbc_flash_bus_ctrl u_fbc_flash_bus_ctrl (
		.core_clk           (core_clk),
		.nrst               (nrst),
		.pins               (pins),
		.data_out           (data_out),
		.data_oe            (data_oe),
		.data_pending_n_out (data_pending_n_out),
		.data_pending_n_oe  (data_pending_n_oe),
		.read_data          (read_data),
		.data_valid         (data_valid),
		.cont_burst         (cont_burst),
		.cfg_load           (cfg_load),
		.cfg_sync           (cfg_sync),
		.read_mode          (read_mode),
		.latched_addr       (latched_addr),
		.burst_tick         (burst_tick),
		.device_active      (device_active),
		.cmd_valid          (cmd_valid),
		.cmd                (cmd),
		.op                 (op),
		.op_grant           (op_grant),
		.op_fail            (op_fail),
		.auto_reset         (auto_reset),
		.status_clear       (status_clear),
		.status             (status)
	);

	// Free-running 250 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Pulse counters sampled mid-cycle, and the hang limit.
	always @(negedge core_clk) begin
		cycles++;
		n_cmd += int'(cmd_valid === 1'b1);
		n_grant += int'(op_grant === 1'b1);
		n_ref += int'(op_fail === 1'b1);
		n_tick += int'(burst_tick === 1'b1);
		if (cycles == 4000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic cfg(input logic s);
		@(posedge core_clk);
		cfg_sync <= s;
		cfg_load <= 1'b1;
		@(posedge core_clk);
		cfg_load <= 1'b0;
		settle(2);
	endtask

	// One program or erase request after clearing the flags.
	task automatic do_op(input logic e, input logic [ADDR_W-1:0] a, input int g,
		input logic [2:0] f);
		int g0;
		int r0;
		@(posedge core_clk);
		status_clear <= 1'b1;
		@(posedge core_clk);
		status_clear <= 1'b0;
		g0 = n_grant;
		r0 = n_ref;
		op <= '{1'b1, e, a};
		@(posedge core_clk);
		op.start <= 1'b0;
		settle(2);
		`CHK("grant", g0 + g, n_grant)
		`CHK("refuse", r0 + 1 - g, n_ref)
		`CHK("status", f, status)
	endtask

	task automatic t_write();
		int c;
		u_fbc_host_model.ctl(6'b011100);
		c = n_cmd;
		u_fbc_host_model.write(20'hABCDE, 16'h1234);
		`CHK("cmd count", c + 1, n_cmd)
		`CHK("cmd", {20'hABCDE, 16'h1234}, cmd)
		`CHK("active", 1'b1, device_active)
		u_fbc_host_model.ctl(6'b111100);
		`CHK("standby", 1'b0, device_active)
		u_fbc_host_model.write(20'h00001, 16'h0001);
		`CHK("deselected write", c + 1, n_cmd)
		u_fbc_host_model.ctl(6'b011101);
		u_fbc_host_model.write(20'h00002, 16'h0002);
		`CHK("low core write", c + 1, n_cmd)
	endtask

	task automatic t_latch();
		u_fbc_host_model.latch(20'h12345, 1'b0);
		`CHK("latched", 20'h12345, latched_addr)
		u_fbc_host_model.latch(20'h54321, 1'b1);
		`CHK("transparent", 20'h54321, latched_addr)
		u_fbc_host_model.latch(20'h0F0F0, 1'b0);
		`CHK("relatched", 20'h0F0F0, latched_addr)
	endtask

	task automatic t_op();
		u_fbc_host_model.ctl(6'b011000);
		do_op(1'b1, 20'h00000, 0, 3'h5);
		do_op(1'b0, 20'h48000, 0, 3'h3);
		do_op(1'b0, 20'hF8000, 0, 3'h3);
		do_op(1'b1, 20'hFA000, 1, 3'h0);
		u_fbc_host_model.ctl(6'b011100);
		do_op(1'b1, 20'h00000, 1, 3'h0);
		u_fbc_host_model.ctl(6'b011110);
		do_op(1'b0, 20'h48000, 0, 3'h0);
	endtask

	task automatic t_reset();
		int c;
		u_fbc_host_model.ctl(6'b011000);
		do_op(1'b0, 20'h00000, 0, 3'h3);
		cfg(1'b1);
		`CHK("mode sync", FBC_RM_SYNC, read_mode)
		u_fbc_host_model.ctl(6'b010000);
		settle(1);
		`CHK("automation reset", 1'b1, auto_reset)
		`CHK("flags cleared", 3'h0, status)
		`CHK("mode in reset", FBC_RM_ASYNC, read_mode)
		c = n_cmd;
		u_fbc_host_model.write(20'h00003, 16'h0003);
		`CHK("write in reset", c, n_cmd)
		u_fbc_host_model.ctl(6'b011100);
		settle(1);
		`CHK("reset exit", 1'b0, auto_reset)
		`CHK("mode after", FBC_RM_ASYNC, read_mode)
	endtask

	task automatic t_read();
		u_fbc_host_model.ctl(6'b001100);
		settle(1);
		`CHK("data oe", 16'hFFFF, data_oe)
		`CHK("data", 16'hC3A5, data_out)
		@(posedge core_clk);
		read_data <= 16'h5A3C;
		settle(2);
		`CHK("data new", 16'h5A3C, data_out)
		`CHK("wait async", 1'b0, data_pending_n_oe)
		u_fbc_host_model.ctl(6'b011100);
		settle(1);
		`CHK("gate off", 16'h0000, data_oe)
		u_fbc_host_model.ctl(6'b101100);
		settle(1);
		`CHK("deselected", 16'h0000, data_oe)
	endtask

	task automatic t_wait();
		int c;
		cfg(1'b1);
		@(posedge core_clk);
		cont_burst <= 1'b1;
		u_fbc_host_model.ctl(6'b001100);
		settle(1);
		`CHK("wait oe", 1'b1, data_pending_n_oe)
		`CHK("wait low", 1'b0, data_pending_n_out)
		@(posedge core_clk);
		data_valid <= 1'b1;
		settle(2);
		`CHK("wait high", 1'b1, data_pending_n_out)
		c = n_tick;
		u_fbc_host_model.burst(4);
		`CHK("ticks", c + 4, n_tick)
		u_fbc_host_model.ctl(6'b011100);
		settle(1);
		`CHK("wait gated", 1'b0, data_pending_n_oe)
		@(posedge core_clk);
		cont_burst <= 1'b0;
		u_fbc_host_model.ctl(6'b001100);
		settle(1);
		`CHK("wait released", 1'b0, data_pending_n_oe)
		cfg(1'b0);
		c = n_tick;
		u_fbc_host_model.burst(4);
		settle(2);
		`CHK("async ticks", c, n_tick)
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		{nrst, data_valid, cont_burst, cfg_load, cfg_sync, status_clear} = '0;
		read_data = 16'hC3A5;
		op = '0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		settle(4);
		t_write();
		t_latch();
		t_op();
		t_reset();
		t_read();
		t_wait();
		conclude();
	end

endmodule // fbc_flash_bus_ctrl_test

`default_nettype wire
